/* File: bcr_defines.svh */
`ifndef BCR_DEFINES_SVH
`define BCR_DEFINES_SVH

// ==========================================================================
// Bus geometry and answers
`define BCR_ADDR_W            12
`define BCR_RESP_OKAY         2'h0
`define BCR_RESP_DECERR       2'h3

// ==========================================================================
// Register byte addresses (64-bit registers take two words, low word first)
`define BCR_OFS_CONFIG_LO     12'h1e0
`define BCR_OFS_CONFIG_HI     12'h1e4
`define BCR_OFS_TIMEOUT       12'h1e8
`define BCR_OFS_CHANNEL       12'h1ec
`define BCR_OFS_STAMP_LO      12'h1f0
`define BCR_OFS_STAMP_HI      12'h1f4
`define BCR_OFS_LATCH         12'h1f8
`define BCR_OFS_TICK_LO       12'h1fc
`define BCR_OFS_TICK_HI       12'h200
`define BCR_OFS_OWNER         12'h204
`define BCR_OFS_PROTO_ORDER   12'h208
`define BCR_OFS_DEV_ORDER     12'h20c
`define BCR_SERIAL_BASE       12'h300
`define BCR_OFS_OFFERED       (`BCR_SERIAL_BASE + 12'h000)
`define BCR_OFS_SELECTED      (`BCR_SERIAL_BASE + 12'h004)

// ==========================================================================
// Field positions and values
`define BCR_ENABLE_BIT        0
`define BCR_LATCH_BIT         0
`define BCR_OWNER_W           3
`define BCR_OWNER_AVAILABLE   3'h0
`define BCR_OWNER_EXCLUSIVE   3'h1
`define BCR_TIMEOUT_RESET     32'h0000_0bb8
`define BCR_CHANNEL_RESET     32'h0000_0000
`define BCR_BIG_ENDIAN        32'h0000_0000
`define BCR_PROTO_LITTLE      32'h0fff_ffff
`define BCR_DEV_LITTLE        32'hffff_ffff
`define BCR_RATE_9600         32'h0000_0001
`define BCR_RATES_ALL         32'h0000_00ff

// ==========================================================================
// Timing
`define BCR_CLK_PERIOD_NS     4
`define BCR_MS_NS             1000000

`endif

/* File: bcr_pkg.sv */
`default_nettype none

package bcr_pkg;

  // ========================================================================
  // Decoded register selection.
  typedef enum {
    SEL_NONE, SEL_CONFIG_LO, SEL_CONFIG_HI, SEL_TIMEOUT, SEL_CHANNEL,
    SEL_STAMP_LO, SEL_STAMP_HI, SEL_LATCH, SEL_TICK_LO, SEL_TICK_HI,
    SEL_OWNER, SEL_PROTO, SEL_DEV, SEL_OFFERED, SEL_SELECTED
  } bcr_sel_type;

  // ========================================================================
  // State of the register bank.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        heartbeat_en;
    logic [31:0] timeout_ms;
    logic [31:0] channel;
    logic [63:0] latched;
    logic [2:0]  owner;
    logic [31:0] rate;
    logic        activity;
  } bcr_regs_state_type;

  // State of the keepalive timer.
  typedef struct packed {
    logic [31:0] div;
    logic [31:0] ms;
    logic        expired;
  } bcr_keep_state_type;

endpackage

`default_nettype wire

/* File: bcr_time_counter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bcr_defines.svh"

module bcr_time_counter
  import bcr_pkg::*;
#(
  parameter logic [63:0] TICK_NS = 64'(`BCR_CLK_PERIOD_NS)
)
(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Device time.
  output logic [63:0]      now_ns_o
);

  logic [63:0] now_ns;
  logic [63:0] next_now_ns;

  // ========================================================================
  // Free-running nanosecond count, one tick per clock.
  always_comb
  begin
    next_now_ns = now_ns + TICK_NS;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      now_ns <= 64'h0;
    else
      now_ns <= next_now_ns;
  end

  assign now_ns_o = now_ns;

  // Time advances by exactly one increment per clock.
  time_advance_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !$past(reset_i) |-> now_ns == $past(now_ns) + TICK_NS)
    else $error("Device time did not advance by one increment.");

endmodule

`default_nettype wire

/* File: bcr_keepalive.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bcr_defines.svh"

module bcr_keepalive
  import bcr_pkg::*;
#(
  parameter int CYCLES_PER_MS = `BCR_MS_NS / `BCR_CLK_PERIOD_NS
)
(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Control.
  input  wire logic        armed_i,
  input  wire logic        activity_i,
  input  wire logic [31:0] timeout_ms_i,
  // Result.
  output logic             expired_o
);

  bcr_keep_state_type cur;
  bcr_keep_state_type nxt;

  // ========================================================================
  // Millisecond divider and silence counter, restarted by host activity.
  always_comb
  begin
    nxt = cur;
    nxt.expired = 1'b0;
    if (!armed_i || activity_i || cur.expired)
    begin
      nxt.div = 32'h0;
      nxt.ms  = 32'h0;
    end
    else if (cur.div == 32'(CYCLES_PER_MS - 1))
    begin
      nxt.div = 32'h0;
      nxt.ms  = cur.ms + 32'h1;
      nxt.expired = (cur.ms + 32'h1) >= timeout_ms_i;
    end
    else
    begin
      nxt.div = cur.div + 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      cur <= '0;
    else
      cur <= nxt;
  end

  assign expired_o = cur.expired;

  // Expiry only follows a full millisecond step while armed.
  expiry_cause_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    expired_o |-> $past(armed_i) && !$past(activity_i) && $past(cur.div) == 32'(CYCLES_PER_MS - 1))
    else $error("Keepalive expired without a timed-out millisecond.");

endmodule

`default_nettype wire

/* File: bcr_regs.sv */
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "bcr_defines.svh"

// How it works
// - Config word bit 0 enables heartbeat timer.
// - Heartbeat timeout in ms, resets to 3000.
// - Timeout register present only with privilege capability.
// - Event channel number resets to zero, host-written.
// - Channel register present only with channel capability.
// - Free-running ns counter; latched value resets zero.
// - Latch write bit 0 captures time, self-clearing.
// - Latch and tick registers follow timestamp capability.
// - Tick register reports nanoseconds per counter tick.
// - Ownership state 0 available, 1 exclusive.
// - Ownership register present only with privilege capability.
// - Protocol byte order: 0 or 0x0fffffff.
// - Device byte order: 0 or 0xffffffff.
// - Byte-order registers follow their capability bit.
// - Serial map: offered rates, then selected rate.
// - Rates one-hot; selected word exactly one bit.
// - Offered word may hold several rates.
// - Capability bit 1 marks privilege support.
module bcr_regs
  import bcr_pkg::*;
#(
  parameter bit          CAP_PRIVILEGE = 1'b1,
  parameter bit          CAP_CHANNEL   = 1'b1,
  parameter bit          CAP_TIMESTAMP = 1'b1,
  parameter bit          CAP_ORDER     = 1'b1,
  parameter bit          CAP_SERIAL    = 1'b1,
  parameter bit          LITTLE_ENDIAN = 1'b1,
  parameter logic [31:0] RATES_OFFERED = `BCR_RATES_ALL,
  parameter logic [31:0] RATE_RESET    = `BCR_RATE_9600,
  parameter logic [63:0] TICK_NS       = 64'(`BCR_CLK_PERIOD_NS),
  parameter int          CYCLES_PER_MS = `BCR_MS_NS / `BCR_CLK_PERIOD_NS
)
(
  // Clock and reset.
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  // AXI4-Lite write address and data.
  input  wire logic [`BCR_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  // AXI4-Lite write response.
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  // AXI4-Lite read.
  input  wire logic [`BCR_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // Device-side controls.
  output logic                       heartbeat_en_o,
  output logic [31:0]                event_channel_number_o,
  output logic [2:0]                 host_ownership_o,
  output logic [31:0]                serial_rate_o
);

  // ========================================================================
  // Declarations
  bcr_regs_state_type cur;
  bcr_regs_state_type nxt;
  logic               aw_take;
  logic               w_take;
  logic               ar_take;
  logic               do_write;
  logic [11:0]        wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic [31:0]        wr_word;
  bcr_sel_type        wr_sel;
  bcr_sel_type        rd_sel;
  logic [31:0]        rd_word;
  logic [63:0]        now_ns;
  logic               expired;

  localparam logic [31:0] PROTO_ORDER = LITTLE_ENDIAN ? `BCR_PROTO_LITTLE : `BCR_BIG_ENDIAN;
  localparam logic [31:0] DEV_ORDER   = LITTLE_ENDIAN ? `BCR_DEV_LITTLE : `BCR_BIG_ENDIAN;
  localparam bit          SINGLE_RATE = $onehot(RATES_OFFERED);

  // ========================================================================
  // Address decoding, gated by the capability parameters.
  function automatic bcr_sel_type decode(input logic [11:0] addr);
    logic [11:0] word;
    word = {addr[11:2], 2'h0};
    decode = SEL_NONE;
    case (word)
      `BCR_OFS_CONFIG_LO:   decode = SEL_CONFIG_LO;
      `BCR_OFS_CONFIG_HI:   decode = SEL_CONFIG_HI;
      `BCR_OFS_TIMEOUT:     if (CAP_PRIVILEGE) decode = SEL_TIMEOUT;
      `BCR_OFS_CHANNEL:     if (CAP_CHANNEL) decode = SEL_CHANNEL;
      `BCR_OFS_STAMP_LO:    if (CAP_TIMESTAMP) decode = SEL_STAMP_LO;
      `BCR_OFS_STAMP_HI:    if (CAP_TIMESTAMP) decode = SEL_STAMP_HI;
      `BCR_OFS_LATCH:       if (CAP_TIMESTAMP) decode = SEL_LATCH;
      `BCR_OFS_TICK_LO:     if (CAP_TIMESTAMP) decode = SEL_TICK_LO;
      `BCR_OFS_TICK_HI:     if (CAP_TIMESTAMP) decode = SEL_TICK_HI;
      `BCR_OFS_OWNER:       if (CAP_PRIVILEGE) decode = SEL_OWNER;
      `BCR_OFS_PROTO_ORDER: if (CAP_ORDER) decode = SEL_PROTO;
      `BCR_OFS_DEV_ORDER:   if (CAP_ORDER) decode = SEL_DEV;
      `BCR_OFS_OFFERED:     if (CAP_SERIAL) decode = SEL_OFFERED;
      `BCR_OFS_SELECTED:    if (CAP_SERIAL) decode = SEL_SELECTED;
      default:              decode = SEL_NONE;
    endcase
  endfunction

  // Merges a written word into an old value under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  // ========================================================================
  // Time base and keepalive timer.
  bcr_time_counter #(
    .TICK_NS       (TICK_NS)
  ) u_time (
    .ref_clk_i     (ref_clk_i),
    .reset_i       (reset_i),
    .now_ns_o      (now_ns)
  );

  bcr_keepalive #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_keep (
    .ref_clk_i     (ref_clk_i),
    .reset_i       (reset_i),
    .armed_i       (cur.heartbeat_en && cur.owner != `BCR_OWNER_AVAILABLE),
    .activity_i    (cur.activity),
    .timeout_ms_i  (cur.timeout_ms),
    .expired_o     (expired)
  );

  // ========================================================================
  // Read data selection from the current state.
  always_comb
  begin
    rd_word = 32'h0;
    unique case (rd_sel)
      SEL_NONE:      rd_word = 32'h0;
      SEL_CONFIG_LO: rd_word = {31'h0, cur.heartbeat_en};
      SEL_CONFIG_HI: rd_word = 32'h0;
      SEL_TIMEOUT:   rd_word = cur.timeout_ms;
      SEL_CHANNEL:   rd_word = cur.channel;
      SEL_STAMP_LO:  rd_word = cur.latched[31:0];
      SEL_STAMP_HI:  rd_word = cur.latched[63:32];
      SEL_LATCH:     rd_word = 32'h0;
      SEL_TICK_LO:   rd_word = TICK_NS[31:0];
      SEL_TICK_HI:   rd_word = TICK_NS[63:32];
      SEL_OWNER:     rd_word = {29'h0, cur.owner};
      SEL_PROTO:     rd_word = PROTO_ORDER;
      SEL_DEV:       rd_word = DEV_ORDER;
      SEL_OFFERED:   rd_word = RATES_OFFERED;
      SEL_SELECTED:  rd_word = cur.rate;
    endcase
  end

  // ========================================================================
  // Next state: bus handshakes, register writes and hardware updates.
  always_comb
  begin
    aw_take  = s_axi_awvalid_i && cur.awready;
    w_take   = s_axi_wvalid_i && cur.wready;
    ar_take  = s_axi_arvalid_i && cur.arready;
    wr_addr  = aw_take ? s_axi_awaddr_i : cur.aw_addr;
    wr_data  = w_take ? s_axi_wdata_i : cur.w_data;
    wr_strb  = w_take ? s_axi_wstrb_i : cur.w_strb;
    do_write = (cur.aw_held || aw_take) && (cur.w_held || w_take) && !cur.bvalid;
    wr_sel   = decode(wr_addr);
    rd_sel   = decode(s_axi_araddr_i);
    wr_word  = 32'h0;
    nxt      = cur;
    nxt.activity = aw_take || ar_take;

    // Address and data are accepted in either order.
    if (aw_take)
    begin
      nxt.aw_held = 1'b1;
      nxt.aw_addr = s_axi_awaddr_i;
    end
    if (w_take)
    begin
      nxt.w_held = 1'b1;
      nxt.w_data = s_axi_wdata_i;
      nxt.w_strb = s_axi_wstrb_i;
    end

    // Ownership returns to available when the host falls silent.
    if (expired)
      nxt.owner = `BCR_OWNER_AVAILABLE;

    // Register write, answered in the same edge that completes the pair.
    if (do_write)
    begin
      nxt.aw_held = 1'b0;
      nxt.w_held  = 1'b0;
      nxt.bvalid  = 1'b1;
      nxt.bresp   = (wr_sel == SEL_NONE) ? `BCR_RESP_DECERR : `BCR_RESP_OKAY;
      unique case (wr_sel)
        SEL_CONFIG_LO:
          if (wr_strb[0])
            nxt.heartbeat_en = wr_data[`BCR_ENABLE_BIT];
        SEL_TIMEOUT:
          nxt.timeout_ms = merge(cur.timeout_ms, wr_data, wr_strb);
        SEL_CHANNEL:
          nxt.channel = merge(cur.channel, wr_data, wr_strb);
        SEL_LATCH:
          if (wr_strb[0] && wr_data[`BCR_LATCH_BIT])
            nxt.latched = now_ns;
        SEL_OWNER:
        begin
          wr_word = merge({29'h0, cur.owner}, wr_data, wr_strb);
          if (wr_word[2:0] == `BCR_OWNER_AVAILABLE || wr_word[2:0] == `BCR_OWNER_EXCLUSIVE)
            nxt.owner = wr_word[2:0];
        end
        SEL_SELECTED:
        begin
          wr_word = merge(cur.rate, wr_data, wr_strb);
          if (!SINGLE_RATE && $onehot(wr_word) && (wr_word & ~RATES_OFFERED) == 32'h0)
            nxt.rate = wr_word;
        end
        default:
          nxt.rate = nxt.rate;
      endcase
    end
    if (cur.bvalid && s_axi_bready_i)
      nxt.bvalid = 1'b0;
    nxt.awready = !nxt.aw_held && !nxt.bvalid;
    nxt.wready  = !nxt.w_held && !nxt.bvalid;

    // Read answered at the edge that takes the address.
    if (ar_take)
    begin
      nxt.rvalid = 1'b1;
      nxt.rdata  = rd_word;
      nxt.rresp  = (rd_sel == SEL_NONE) ? `BCR_RESP_DECERR : `BCR_RESP_OKAY;
    end
    else if (cur.rvalid && s_axi_rready_i)
    begin
      nxt.rvalid = 1'b0;
    end
    nxt.arready = !nxt.rvalid;
  end

  // ========================================================================
  // State register with reset values.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      cur            <= '0;
      cur.awready    <= 1'b1;
      cur.wready     <= 1'b1;
      cur.arready    <= 1'b1;
      cur.timeout_ms <= `BCR_TIMEOUT_RESET;
      cur.channel    <= `BCR_CHANNEL_RESET;
      cur.owner      <= `BCR_OWNER_AVAILABLE;
      cur.rate       <= RATE_RESET;
    end
    else
    begin
      cur <= nxt;
    end
  end

  // Outputs come straight from the state register.
  assign s_axi_awready_o        = cur.awready;
  assign s_axi_wready_o         = cur.wready;
  assign s_axi_bresp_o          = cur.bresp;
  assign s_axi_bvalid_o         = cur.bvalid;
  assign s_axi_arready_o        = cur.arready;
  assign s_axi_rdata_o          = cur.rdata;
  assign s_axi_rresp_o          = cur.rresp;
  assign s_axi_rvalid_o         = cur.rvalid;
  assign heartbeat_en_o         = cur.heartbeat_en;
  assign event_channel_number_o = cur.channel;
  assign host_ownership_o       = cur.owner;
  assign serial_rate_o          = cur.rate;

  // ========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence write_to(bcr_sel_type s);
    do_write && wr_sel == s;
  endsequence

  sequence read_of(bcr_sel_type s);
    ar_take && rd_sel == s;
  endsequence

  reset_values_a: assert property (disable iff (1'b0) reset_i |=>
    cur.timeout_ms == `BCR_TIMEOUT_RESET && cur.channel == `BCR_CHANNEL_RESET
    && cur.latched == 64'h0 && cur.owner == `BCR_OWNER_AVAILABLE && !cur.heartbeat_en)
    else $error("Register reset values are wrong.");

  stamp_latch_a: assert property (write_to(SEL_LATCH) ##0 (wr_strb[0] && wr_data[0])
    |=> cur.latched == $past(now_ns) ##1 $stable(cur.latched) || $past(do_write))
    else $error("Latch write did not capture device time.");

  channel_write_a: assert property (write_to(SEL_CHANNEL) ##0 (wr_strb == 4'hf)
    |=> event_channel_number_o == $past(wr_data))
    else $error("Channel number write was lost.");

  owner_reserved_a: assert property (write_to(SEL_OWNER) ##0 (wr_data[2:1] != 2'h0)
    ##0 !expired |=> host_ownership_o == $past(host_ownership_o))
    else $error("Reserved ownership value was stored.");

  rate_onehot_a: assert property ($onehot(serial_rate_o) && (serial_rate_o & ~RATES_OFFERED) == 32'h0)
    else $error("Selected rate is not one offered rate.");

  expiry_frees_a: assert property (expired && !(do_write && wr_sel == SEL_OWNER)
    |=> host_ownership_o == `BCR_OWNER_AVAILABLE)
    else $error("Keepalive expiry did not free ownership.");

  unmapped_write_a: assert property (write_to(SEL_NONE)
    |=> s_axi_bvalid_o && s_axi_bresp_o == `BCR_RESP_DECERR)
    else $error("Unmapped write not answered with decode error.");

  tick_read_a: assert property (read_of(SEL_TICK_LO)
    |=> s_axi_rvalid_o && s_axi_rdata_o == TICK_NS[31:0] && s_axi_rresp_o == `BCR_RESP_OKAY)
    else $error("Tick register read returned wrong value.");

  order_read_a: assert property (read_of(SEL_PROTO) |=> s_axi_rdata_o == PROTO_ORDER)
    else $error("Protocol byte order read returned wrong value.");

  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("Read answer changed before it was taken.");

  config_upper_a: assert property (read_of(SEL_CONFIG_HI) |=> s_axi_rdata_o == 32'h0)
    else $error("Reserved configuration bits did not read zero.");

endmodule

`default_nettype wire

/* File: bcr_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module bcr_host_model
(
  // Clock.
  input  wire logic        ref_clk_i,
  // Write request and response.
  output var logic [11:0]  awaddr_o,
  output var logic         awvalid_o,
  input  wire logic        awready_i,
  output var logic [31:0]  wdata_o,
  output var logic [3:0]   wstrb_o,
  output var logic         wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output var logic         bready_o,
  // Read request and answer.
  output var logic [11:0]  araddr_o,
  output var logic         arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output var logic         rready_o
);
  // ========================================================================
  // Host bus master

  // The bus starts idle with nothing offered.
  initial
  begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
  end

  // One write: address and data offered together, each dropped when taken.
  task automatic write_word(input logic [11:0] addr, input logic [31:0] data, output logic [1:0] resp);
    @(posedge ref_clk_i);
    awaddr_o <= addr;
    wdata_o <= data;
    wstrb_o <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    forever
    begin
      @(posedge ref_clk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'b0;
      if (wvalid_o && wready_i) wvalid_o <= 1'b0;
      if (bvalid_i) break;
    end
    resp = bresp_i;
    bready_o <= 1'b0;
    awaddr_o <= ~addr;  // Released lines never keep the last value.
    wdata_o <= ~data;
    wstrb_o <= 4'h0;
  endtask

  // One read: address held until taken, answer taken with rready high.
  task automatic read_word(input logic [11:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge ref_clk_i);
    araddr_o <= addr;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    forever
    begin
      @(posedge ref_clk_i);
      if (arvalid_o && arready_i) arvalid_o <= 1'b0;
      if (rvalid_i) break;
    end
    data = rdata_i;
    resp = rresp_i;
    rready_o <= 1'b0;
    araddr_o <= ~addr;
  endtask
endmodule

`default_nettype wire

/* File: test_bootstrap_control_registers.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bcr_defines.svh"

module test_bootstrap_control_registers;
  // ========================================================================
  // Signals and tables
  logic ref_clk_i, reset_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, hb_en;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, chan_o, rate_o, v, got, exp_rate;
  logic [3:0]  wstrb;
  logic [2:0]  own_o, exp_own;
  logic [1:0]  bresp, rresp, bresp_dummy;
  int          num_errors, checks_done, cycles, seed, i, t0, t1;
  localparam logic [11:0] ADR [14] = '{`BCR_OFS_CONFIG_LO, `BCR_OFS_CONFIG_HI, `BCR_OFS_TIMEOUT,
    `BCR_OFS_CHANNEL, `BCR_OFS_STAMP_LO, `BCR_OFS_STAMP_HI, `BCR_OFS_LATCH, `BCR_OFS_TICK_LO,
    `BCR_OFS_TICK_HI, `BCR_OFS_OWNER, `BCR_OFS_PROTO_ORDER, `BCR_OFS_DEV_ORDER, `BCR_OFS_OFFERED,
    `BCR_OFS_SELECTED};
  localparam logic [31:0] VAL [14] = '{32'h0, 32'h0, 32'hbb8, 32'h0, 32'h0, 32'h0, 32'h0, 32'h4,
    32'h0, 32'h0, 32'h0fffffff, 32'hffffffff, 32'hff, 32'h1};

  // ========================================================================
  // Design and host
  bcr_regs #(.CYCLES_PER_MS(4)) bcr_regs_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .heartbeat_en_o(hb_en), .event_channel_number_o(chan_o), .host_ownership_o(own_o),
    .serial_rate_o(rate_o));
  bcr_host_model bcr_host_model_inst (.ref_clk_i(ref_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
    .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

  // ========================================================================
  // Checking helpers

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  // Reads a word and checks data and response.
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [1:0] r;
    bcr_host_model_inst.read_word(a, got, r);
    check(got, e);
    check(32'(r), 32'(er));
  endtask

  // Writes a word and checks the response.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bcr_host_model_inst.write_word(a, d, r);
    check(32'(r), 32'(er));
  endtask

  // Ownership keeps its value when a reserved state is written.
  function automatic logic [2:0] own_after(input logic [2:0] cur, input logic [31:0] d);
    return (d <= 32'h1) ? d[2:0] : cur;
  endfunction

  // The selected rate only takes a single offered rate.
  function automatic logic [31:0] rate_after(input logic [31:0] cur, input logic [31:0] d);
    return ($onehot(d) && (d & 32'hff) != 32'h0) ? d : cur;
  endfunction

  // Prints the counts and the verdict, then stops.
  task automatic close_out;
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ========================================================================
  // Clock, cycle count and hang guard
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Counts cycles and cuts a hang short.
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles > 6000)
    begin
      num_errors++;
      close_out();
    end
  end

  // ========================================================================
  // Main sequence
  initial
  begin
    {num_errors, checks_done, cycles} = '0;
    seed = 88;
    reset_i = 1'b1;
    exp_own = 3'h0;
    exp_rate = 32'h1;
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    // Every register after reset, then an unmapped place.
    for (i = 0; i < 14; i++) rdc(ADR[i], VAL[i], `BCR_RESP_OKAY);
    rdc(12'h100, 32'h0, `BCR_RESP_DECERR);
    wr(12'h100, 32'h1, `BCR_RESP_DECERR);
    // Random traffic to every writable word but the latch, and to read-only ones.
    for (i = 0; i < 8; i++)
    begin
      v = $random(seed) | 32'h1;
      wr(`BCR_OFS_CHANNEL, v, `BCR_RESP_OKAY);
      rdc(`BCR_OFS_CHANNEL, v, `BCR_RESP_OKAY);
      check(chan_o, v);
      v = $random(seed) | 32'h100;
      wr(`BCR_OFS_TIMEOUT, v, `BCR_RESP_OKAY);
      rdc(`BCR_OFS_TIMEOUT, v, `BCR_RESP_OKAY);
      v = $random(seed) & 32'h7;
      exp_own = own_after(exp_own, v);
      wr(`BCR_OFS_OWNER, v, `BCR_RESP_OKAY);
      rdc(`BCR_OFS_OWNER, 32'(exp_own), `BCR_RESP_OKAY);
      check(32'(own_o), 32'(exp_own));
      v = i[0] ? $random(seed) : 32'h1 << ($unsigned($random(seed)) % 8);
      exp_rate = rate_after(exp_rate, v);
      wr(`BCR_OFS_SELECTED, v, `BCR_RESP_OKAY);
      rdc(`BCR_OFS_SELECTED, exp_rate, `BCR_RESP_OKAY);
      check(rate_o, exp_rate);
      v = $random(seed);
      wr(`BCR_OFS_CONFIG_LO, v, `BCR_RESP_OKAY);
      wr(`BCR_OFS_CONFIG_HI, v, `BCR_RESP_OKAY);
      rdc(`BCR_OFS_CONFIG_LO, {31'h0, v[0]}, `BCR_RESP_OKAY);
      rdc(`BCR_OFS_CONFIG_HI, 32'h0, `BCR_RESP_OKAY);
      check(32'(hb_en), 32'(v[0]));
      wr(`BCR_OFS_TICK_LO, v, `BCR_RESP_OKAY);
      rdc(`BCR_OFS_TICK_LO, 32'h4, `BCR_RESP_OKAY);
    end
    // Time capture lands between the cycle counts around the write.
    t0 = (cycles - 12) * 4;
    wr(`BCR_OFS_LATCH, 32'h1, `BCR_RESP_OKAY);
    t1 = (cycles - 12) * 4;
    bcr_host_model_inst.read_word(`BCR_OFS_STAMP_LO, v, bresp_dummy);
    check(32'(v >= t0 && v <= t1 && v[1:0] == 2'h0), 32'h1);
    check(32'(bresp_dummy), 32'(`BCR_RESP_OKAY));
    wr(`BCR_OFS_LATCH, 32'h0, `BCR_RESP_OKAY);
    rdc(`BCR_OFS_STAMP_LO, v, `BCR_RESP_OKAY);
    rdc(`BCR_OFS_LATCH, 32'h0, `BCR_RESP_OKAY);
    // Silence past a two millisecond timeout frees the ownership.
    wr(`BCR_OFS_TIMEOUT, 32'h2, `BCR_RESP_OKAY);
    wr(`BCR_OFS_CONFIG_LO, 32'h1, `BCR_RESP_OKAY);
    wr(`BCR_OFS_OWNER, 32'h1, `BCR_RESP_OKAY);
    repeat (3) @(posedge ref_clk_i);
    check(32'(own_o), 32'h1);
    repeat (30) @(posedge ref_clk_i);
    check(32'(own_o), 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
